// file: ewol_unit.sv
// Wake-on-LAN control/status unit: AHB-Lite slave, banked frame CRC/mask, event flags.
// Assumes the receive path streams frame bytes and reports magic packets and link level.
//
// Behaviour
// - Wake output shape from two-bit type
// - Control bit 18 requests PHY power-down
// - Bank select picks frame for CRC/mask
// - Bit 15 sets power-saving mode
// - Bits 3-6 enable frame 1-4 events
// - Bit 2 enables magic packet event
// - Bits 1/0 enable link up/down events
// - Frame flags at status 3-6, W1C
// - Magic packet flag at status 2, W1C
// - Link flags at status 1/0, W1C
// - CRC register banked by bank select
// - Mask bit n covers frame byte n+1
// - Mask word banked by bank select
//
// The AHB-Lite slave port was chosen for this implementation.
module ewol_unit
  import ewol_pkg::*;
#(
  parameter int NFRAME = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_frame_start,
  input wire logic rx_frame_end,
  input wire logic magic_packet_seen,
  input wire logic link_up_pin,
  output logic wake_out,
  output logic phy_power_down_request,
  output logic power_saving_mode,
  output logic irq
);

  // CRC-32 byte update, shared by all frame matchers
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ EWOL_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  logic [31:0] ctrl_r;
  logic [EWOL_NEVT-1:0] status_r;
  logic [EWOL_NEVT-1:0] irq_en_r;
  logic [31:0] crc_mem_r [NFRAME];
  logic [31:0] mask_mem_r [NFRAME];
  logic [31:0] run_crc_r [NFRAME];
  logic [5:0] byte_idx_r;
  logic [EWOL_NEVT-1:0] evt;
  logic [NFRAME-1:0] frame_hit;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [1:0] bank;
  logic [1:0] shape;
  logic wake_level;
  logic [3:0] pulse_cnt_r;
  logic wake_arm_r;
  logic [2:0] link_sync_r;
  logic link_state_r;

  assign bank = ctrl_r[EWOL_POS_BANK +: 2];
  assign shape = ctrl_r[EWOL_POS_SHAPE +: 2];

  // Address phase capture; slave always ready with OKAY
  wire addr_ok = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data registered at the address phase, valid in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= EWOL_RST_WORD;
    end else if (addr_ok && !hwrite) begin
      if (haddr[7:0] == EWOL_OFS_CTRL) begin
        hrdata <= ctrl_r;
      end else if (haddr[7:0] == EWOL_OFS_STATUS) begin
        hrdata <= {25'h000_0000, status_r};
      end else if (haddr[7:0] == EWOL_OFS_CRC) begin
        hrdata <= crc_mem_r[bank];
      end else if (haddr[7:0] == EWOL_OFS_MASK1) begin
        hrdata <= mask_mem_r[bank];
      end else if (haddr[7:0] == EWOL_OFS_IRQEN) begin
        hrdata <= {25'h000_0000, irq_en_r};
      end else begin
        hrdata <= EWOL_RST_WORD;
      end
    end
  end

  // Control register: writable fields only, reserved bits stay zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= EWOL_RST_WORD;
    end else if (wr_pend_r && wr_addr_r == EWOL_OFS_CTRL) begin
      ctrl_r <= hwdata & EWOL_CTRL_WMASK;
    end
  end

  // Interrupt enable register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_r <= '0;
    end else if (wr_pend_r && wr_addr_r == EWOL_OFS_IRQEN) begin
      irq_en_r <= hwdata[EWOL_NEVT-1:0];
    end
  end

  // Banked CRC and mask storage, written only for the selected frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int f = 0; f < NFRAME; f++) begin
        crc_mem_r[f] <= EWOL_RST_WORD;
        mask_mem_r[f] <= EWOL_RST_WORD;
      end
    end else if (wr_pend_r) begin
      if (wr_addr_r == EWOL_OFS_CRC) begin
        crc_mem_r[bank] <= hwdata;
      end else if (wr_addr_r == EWOL_OFS_MASK1) begin
        mask_mem_r[bank] <= hwdata;
      end
    end
  end

  // Per-frame CRC over bytes selected by the mask; byte n+1 uses mask bit n
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byte_idx_r <= 6'd0;
      for (int f = 0; f < NFRAME; f++) begin
        run_crc_r[f] <= EWOL_CRC_INIT;
      end
    end else if (rx_frame_start) begin
      byte_idx_r <= 6'd0;
      for (int f = 0; f < NFRAME; f++) begin
        run_crc_r[f] <= EWOL_CRC_INIT;
      end
    end else if (rx_byte_valid && byte_idx_r < EWOL_MASK_BYTES) begin
      byte_idx_r <= byte_idx_r + 6'd1;
      for (int f = 0; f < NFRAME; f++) begin
        if (mask_mem_r[f][byte_idx_r[4:0]]) begin
          run_crc_r[f] <= crc_byte(run_crc_r[f], rx_byte);
        end
      end
    end
  end

  // Frame match at frame end compares the finished CRC with the stored one
  always_comb begin
    for (int f = 0; f < NFRAME; f++) begin
      frame_hit[f] = rx_frame_end && ((~run_crc_r[f]) == crc_mem_r[f]);
    end
  end

  // Link level through three flops; change counts when last two agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_sync_r <= 3'b000;
      link_state_r <= 1'b0;
    end else begin
      link_sync_r <= {link_sync_r[1:0], link_up_pin};
      if (link_sync_r[2] == link_sync_r[1]) begin
        link_state_r <= link_sync_r[2];
      end
    end
  end

  wire link_agree = link_sync_r[2] == link_sync_r[1];
  wire link_rise = link_agree && link_sync_r[2] && !link_state_r;
  wire link_fall = link_agree && !link_sync_r[2] && link_state_r;

  // Events gated by their enables
  always_comb begin
    evt[0] = link_fall && ctrl_r[0];
    evt[1] = link_rise && ctrl_r[1];
    evt[2] = magic_packet_seen && ctrl_r[2];
    evt[6:3] = frame_hit[3:0] & ctrl_r[6:3];
  end

  // Sticky status; a write of one clears, a new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= '0;
    end else begin
      if (wr_pend_r && wr_addr_r == EWOL_OFS_CLEAR) begin
        status_r <= (status_r & ~hwdata[EWOL_NEVT-1:0]) | evt;
      end else if (wr_pend_r && wr_addr_r == EWOL_OFS_STATUS) begin
        status_r <= (status_r & ~hwdata[EWOL_NEVT-1:0]) | evt;
      end else begin
        status_r <= status_r | evt;
      end
    end
  end

  // Wake output: level follows any flag; pulse fires once per new event
  assign wake_level = |status_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_cnt_r <= 4'd0;
      wake_arm_r <= 1'b0;
    end else begin
      wake_arm_r <= |evt;
      if (wake_arm_r) begin
        pulse_cnt_r <= EWOL_PULSE_CYC;
      end else if (pulse_cnt_r != 4'd0) begin
        pulse_cnt_r <= pulse_cnt_r - 4'd1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_out <= 1'b0;
    end else begin
      case (shape)
        EWOL_SHAPE_HIGH: wake_out <= wake_level;
        EWOL_SHAPE_LOW: wake_out <= !wake_level;
        EWOL_SHAPE_PPULSE: wake_out <= (pulse_cnt_r != 4'd0) || wake_arm_r;
        default: wake_out <= !((pulse_cnt_r != 4'd0) || wake_arm_r);
      endcase
    end
  end

  // Registered control outputs and interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_power_down_request <= 1'b0;
      power_saving_mode <= 1'b0;
      irq <= 1'b0;
    end else begin
      phy_power_down_request <= ctrl_r[EWOL_POS_PHYPD];
      power_saving_mode <= ctrl_r[EWOL_POS_PSAVE];
      irq <= |(status_r & irq_en_r);
    end
  end

  AST_PHYPD: assert property (@(posedge hclk) disable iff (!hresetn)
    phy_power_down_request == $past(ctrl_r[EWOL_POS_PHYPD]))
    else $error("PHY power-down output not following control bit");
  AST_PSAVE: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(ctrl_r[EWOL_POS_PSAVE]) |=> power_saving_mode)
    else $error("Power saving mode not entered");
  AST_SHAPE_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
    (shape == 2'b00) && $stable(shape) |=> wake_out == $past(wake_level))
    else $error("Active high wake level wrong");
  AST_SHAPE_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
    (shape == 2'b01) && $stable(shape) |=> wake_out == !$past(wake_level))
    else $error("Active low wake level wrong");
  AST_NO_EVT_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_r[2] && !status_r[2] && !(wr_pend_r && wr_addr_r == EWOL_OFS_CTRL)
    |=> !status_r[2])
    else $error("Magic flag set while disabled");
  AST_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
    status_r[0] && !wr_pend_r |=> status_r[0])
    else $error("Link down flag lost without clear");
  AST_W1C: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_addr_r == EWOL_OFS_STATUS && hwdata[3] && !evt[3] |=> !status_r[3])
    else $error("Frame 1 flag not cleared by write one");
  AST_MAGIC_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    magic_packet_seen && ctrl_r[2] |=> status_r[2])
    else $error("Magic packet flag not set");
  AST_CRC_BANK: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_addr_r == EWOL_OFS_CRC |=> crc_mem_r[$past(bank)] == $past(hwdata))
    else $error("Banked CRC write lost");
  AST_MASK_BANK: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_addr_r == EWOL_OFS_MASK1 |=> mask_mem_r[$past(bank)] == $past(hwdata))
    else $error("Banked mask write lost");

  // Read data mirrors the addressed register one edge after the address phase
  AST_RD_CTRL: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && haddr[7:0] == EWOL_OFS_CTRL |=> hrdata == $past(ctrl_r))
    else $error("Control read data wrong");
  AST_RD_STATUS: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && haddr[7:0] == EWOL_OFS_STATUS |=> hrdata[6:0] == $past(status_r))
    else $error("Status read data wrong");
  AST_RD_CRC: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && haddr[7:0] == EWOL_OFS_CRC |=> hrdata == $past(crc_mem_r[bank]))
    else $error("Banked CRC read data wrong");
  AST_RD_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && haddr[7:0] == EWOL_OFS_MASK1 |=> hrdata == $past(mask_mem_r[bank]))
    else $error("Banked mask read data wrong");

  // Control storage keeps reserved bits clear; CRC and mask bank 0 untouched by writes to other banks
  AST_CTRL_RSVD: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl_r & ~EWOL_CTRL_WMASK) == 32'h0000_0000)
    else $error("Reserved control bit set");
  AST_CRC_OTHER: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_addr_r == EWOL_OFS_CRC && bank != 2'd0 |=> $stable(crc_mem_r[0]))
    else $error("CRC write hit an unselected frame");
  AST_MASK_OTHER: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_addr_r == EWOL_OFS_MASK1 && bank != 2'd0 |=> $stable(mask_mem_r[0]))
    else $error("Mask write hit an unselected frame");
  AST_PSAVE_FALL: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(ctrl_r[EWOL_POS_PSAVE]) |=> !power_saving_mode)
    else $error("Power saving mode not left");

  // Event flags: set by enabled events, cleared by a write of one
  AST_LINK_UP_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    link_rise && ctrl_r[1] |=> status_r[1])
    else $error("Link up flag not set");
  AST_LINK_DN_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    link_fall && ctrl_r[0] |=> status_r[0])
    else $error("Link down flag not set");
  AST_FRAME4_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    frame_hit[3] && ctrl_r[6] |=> status_r[6])
    else $error("Frame 4 flag not set");
  AST_SET_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
    evt[2] && wr_pend_r && hwdata[2] |=> status_r[2])
    else $error("Clear beat a new magic event");
  AST_CLR_MAGIC: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_addr_r == EWOL_OFS_CLEAR && hwdata[2] && !evt[2] |=> !status_r[2])
    else $error("Magic flag not cleared");
  AST_CLR_LINK: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_addr_r == EWOL_OFS_STATUS && hwdata[1] && !evt[1] |=> !status_r[1])
    else $error("Link up flag not cleared");
  AST_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == $past(|(status_r & irq_en_r)))
    else $error("Interrupt level wrong");

  // Frame CRC engine: restart, byte count and masked bytes
  AST_CRC_RESTART: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_frame_start |=> run_crc_r[0] == EWOL_CRC_INIT && byte_idx_r == 6'd0)
    else $error("Frame CRC not restarted");
  AST_BYTE_IDX: assert property (@(posedge hclk) disable iff (!hresetn)
    byte_idx_r <= EWOL_MASK_BYTES)
    else $error("Byte index past mask word");
  AST_MASK_SKIP: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_byte_valid && !rx_frame_start && byte_idx_r < EWOL_MASK_BYTES
    && !mask_mem_r[0][byte_idx_r[4:0]] |=> $stable(run_crc_r[0]))
    else $error("Masked-out byte entered CRC");

  // Pulse shapes: armed pulse, hold while counting, idle afterwards
  AST_PULSE_LOAD: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_arm_r |=> pulse_cnt_r == EWOL_PULSE_CYC)
    else $error("Pulse counter not loaded");
  AST_PPULSE_ARM: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_arm_r && shape == 2'b10 |=> wake_out)
    else $error("Positive pulse not started");
  AST_PPULSE_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    pulse_cnt_r != 4'd0 && shape == 2'b10 |=> wake_out)
    else $error("Positive pulse cut short");
  AST_PPULSE_END: assert property (@(posedge hclk) disable iff (!hresetn)
    pulse_cnt_r == 4'd0 && !wake_arm_r && shape == 2'b10 |=> !wake_out)
    else $error("Positive pulse too long");
  AST_NPULSE_ARM: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_arm_r && shape == 2'b11 |=> !wake_out)
    else $error("Negative pulse not started");

  COV_MAGIC: cover property (@(posedge hclk) disable iff (!hresetn) evt[2] ##2 irq);
  COV_FRAME: cover property (@(posedge hclk) disable iff (!hresetn) |evt[6:3]);
  COV_LINK_UP: cover property (@(posedge hclk) disable iff (!hresetn) evt[1]);
  COV_PULSE: cover property (@(posedge hclk) disable iff (!hresetn) shape == 2'b10 && wake_out);
  COV_NPULSE: cover property (@(posedge hclk) disable iff (!hresetn) shape == 2'b11 && !wake_out);

endmodule : ewol_unit

// file: ewol_pkg.sv
// Package for the wake-on-LAN unit: register offsets, field positions, reset values.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package ewol_pkg;
  localparam logic [7:0] EWOL_OFS_CTRL = 8'h70;
  localparam logic [7:0] EWOL_OFS_STATUS = 8'h74;
  localparam logic [7:0] EWOL_OFS_CRC = 8'h78;
  localparam logic [7:0] EWOL_OFS_MASK1 = 8'h80;
  localparam logic [7:0] EWOL_OFS_CLEAR = 8'h90;
  localparam logic [7:0] EWOL_OFS_IRQEN = 8'h94;
  localparam int EWOL_POS_SHAPE = 24;
  localparam int EWOL_POS_PHYPD = 18;
  localparam int EWOL_POS_BANK = 16;
  localparam int EWOL_POS_PSAVE = 15;
  localparam int EWOL_NEVT = 7;
  localparam logic [31:0] EWOL_CTRL_WMASK = 32'h0307_807F;
  localparam logic [31:0] EWOL_RST_WORD = 32'h0000_0000;
  localparam logic [31:0] EWOL_CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] EWOL_CRC_POLY = 32'hEDB8_8320;
  localparam logic [5:0] EWOL_MASK_BYTES = 6'd32;
  localparam int EWOL_PULSE_NS = 100;
  localparam int EWOL_CLK_NS = 20;
  localparam logic [3:0] EWOL_PULSE_CYC = 4'((EWOL_PULSE_NS + EWOL_CLK_NS - 1) / EWOL_CLK_NS);
  typedef enum logic [1:0] {
    EWOL_SHAPE_HIGH = 2'b00,
    EWOL_SHAPE_LOW = 2'b01,
    EWOL_SHAPE_PPULSE = 2'b10,
    EWOL_SHAPE_NPULSE = 2'b11
  } ewol_shape_e;
endpackage : ewol_pkg

// file: ewol_link_partner.sv
// Link partner model: frame bytes, magic packet pulses and link level.
// Assumes the controller clock; signals change just after a rising edge.
module ewol_link_partner (
  input wire logic hclk,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_frame_start,
  output logic rx_frame_end,
  output logic magic_packet_seen,
  output logic link_up_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet link at time zero
  initial begin
    {rx_byte_valid, rx_frame_start, rx_frame_end, magic_packet_seen, link_up_pin} = '0;
    rx_byte = 8'h5A;
  end
  // One-cycle magic packet indication
  task automatic magic();
    @(posedge hclk) magic_packet_seen <= 1'b1;
    @(posedge hclk) magic_packet_seen <= 1'b0;
  endtask : magic
  // New link level
  task automatic link(input logic v);
    @(posedge hclk) link_up_pin <= v;
  endtask : link
  // 32-byte frame; idle cycles between bytes show the inverted last byte
  task automatic frame(input logic [7:0] fb [32], input int gap);
    @(posedge hclk) rx_frame_start <= 1'b1;
    @(posedge hclk) rx_frame_start <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= fb[i];
      @(posedge hclk);
      if (gap > 0) begin
        rx_byte_valid <= 1'b0;
        rx_byte <= ~fb[i];
        repeat (gap) @(posedge hclk);
      end
    end
    rx_byte_valid <= 1'b0;
    rx_byte <= ~fb[31];
    rx_frame_end <= 1'b1;
    @(posedge hclk) rx_frame_end <= 1'b0;
  endtask : frame
endmodule : ewol_link_partner

// file: ewol_unit_bench.sv
// Self-checking bench for the wake-on-LAN unit against a register and event model.
// Assumes one AHB-Lite master, the link partner model and a 50 MHz clock.
module ewol_unit_bench
  import ewol_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, wake_out;
  logic rx_byte_valid, rx_frame_start, rx_frame_end, magic_packet_seen, link_up_pin;
  logic phy_power_down_request, power_saving_mode;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] rx_byte;
  logic [7:0] fb [32];
  logic [31:0] haddr, hwdata, hrdata, seed, mdl_ctrl, mdl_sts, rd;
  logic [31:0] mdl_crc [4];
  logic [31:0] mdl_mask [4];
  int err_count, samples_checked;
  assign hready = hreadyout;
  ewol_unit u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .rx_byte_valid, .rx_byte, .rx_frame_start, .rx_frame_end,
    .magic_packet_seen, .link_up_pin, .wake_out, .phy_power_down_request,
    .power_saving_mode, .irq);
  ewol_link_partner u_phy (.hclk, .rx_byte_valid, .rx_byte, .rx_frame_start, .rx_frame_end,
    .magic_packet_seen, .link_up_pin);
  // 50 MHz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    test_done();
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  // Reference CRC over the bytes picked by the mask
  function automatic logic [31:0] crc_of(input logic [31:0] m);
    logic [31:0] c;
    c = EWOL_CRC_INIT;
    for (int i = 0; i < 32; i++) begin
      if (m[i]) begin
        c = c ^ 32'(fb[i]);
        for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ EWOL_CRC_POLY : c >> 1;
      end
    end
    return ~c;
  endfunction : crc_of
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One single-word AHB-Lite transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= 32'(a);
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wr ? d : rnd();
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk(32'(hresp), 32'h0000_0000);
  endtask : rdc
  task automatic ctl(input logic [31:0] v);
    mdl_ctrl = v & EWOL_CTRL_WMASK;
    ahb(1'b1, EWOL_OFS_CTRL, v);
  endtask : ctl
  task automatic clr(input logic [7:0] a, input logic [31:0] m);
    ahb(1'b1, a, m);
    mdl_sts = mdl_sts & ~m;
  endtask : clr
  task automatic evt(input logic [6:0] e);
    mdl_sts = mdl_sts | 32'(e & mdl_ctrl[6:0]);
  endtask : evt
  task automatic test_done();
    $display("Compared %0d values, %0d mismatches", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata, mdl_ctrl, mdl_sts} = '0;
    {err_count, samples_checked} = '0;
    hsel = 1'b1;
    hsize = 3'b010;
    seed = 32'hd92b_aa70;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(EWOL_OFS_CTRL, EWOL_RST_WORD);
    rdc(EWOL_OFS_STATUS, EWOL_RST_WORD);
    rdc(EWOL_OFS_CRC, EWOL_RST_WORD);
    rdc(EWOL_OFS_MASK1, EWOL_RST_WORD);
    rdc(8'hFC, 32'h0000_0000);
    // Random control words: reserved bits read zero, levels follow
    repeat (4) begin
      ctl(rnd());
      @(posedge hclk);
      #1 chk(32'({phy_power_down_request, power_saving_mode}), 32'({mdl_ctrl[18], mdl_ctrl[15]}));
      rdc(EWOL_OFS_CTRL, mdl_ctrl);
    end
    // Banked CRC and mask, read back in reverse bank order
    for (int b = 0; b < 4; b++) begin
      ctl(32'(b) << EWOL_POS_BANK);
      mdl_crc[b] = rnd();
      mdl_mask[b] = rnd();
      ahb(1'b1, EWOL_OFS_CRC, mdl_crc[b]);
      ahb(1'b1, EWOL_OFS_MASK1, mdl_mask[b]);
    end
    for (int b = 3; b >= 0; b--) begin
      ctl(32'(b) << EWOL_POS_BANK);
      rdc(EWOL_OFS_CRC, mdl_crc[b]);
      rdc(EWOL_OFS_MASK1, mdl_mask[b]);
    end
    // Magic packet ignored while disabled, then flagged with irq and cleared
    ahb(1'b1, EWOL_OFS_IRQEN, 32'h0000_0007);
    rdc(EWOL_OFS_IRQEN, 32'h0000_0007);
    u_phy.magic();
    evt(7'h04);
    rdc(EWOL_OFS_STATUS, mdl_sts);
    ctl(32'h0000_0004);
    u_phy.magic();
    evt(7'h04);
    repeat (3) @(posedge hclk);
    #1 chk(32'(irq), 32'h0000_0001);
    rdc(EWOL_OFS_STATUS, mdl_sts);
    clr(EWOL_OFS_CLEAR, 32'h0000_0004);
    rdc(EWOL_OFS_STATUS, mdl_sts);
    #1 chk(32'(irq), 32'h0000_0000);
    // Link up then down, cleared by writing ones to status
    ctl(32'h0000_0003);
    u_phy.link(1'b1);
    repeat (8) @(posedge hclk);
    evt(7'h02);
    rdc(EWOL_OFS_STATUS, mdl_sts);
    u_phy.link(1'b0);
    repeat (8) @(posedge hclk);
    evt(7'h01);
    rdc(EWOL_OFS_STATUS, mdl_sts);
    clr(EWOL_OFS_STATUS, 32'h0000_0003);
    rdc(EWOL_OFS_STATUS, mdl_sts);
    // Each frame bank matched over its masked bytes, slower each time
    for (int f = 0; f < 4; f++) begin
      ctl((32'(f) << EWOL_POS_BANK) | (32'h0000_0008 << f));
      foreach (fb[i]) fb[i] = 8'(rnd());
      mdl_crc[f] = crc_of(mdl_mask[f]);
      ahb(1'b1, EWOL_OFS_CRC, mdl_crc[f]);
      u_phy.frame(fb, f);
      evt(7'(8 << f));
      repeat (2) @(posedge hclk);
      rdc(EWOL_OFS_STATUS, mdl_sts);
    end
    #1 chk(32'(irq), 32'h0000_0000);
    // Every wake output shape, idle and active
    for (int s = 0; s < 4; s++) begin
      ctl((32'(s) << EWOL_POS_SHAPE) | 32'h0000_0004);
      clr(EWOL_OFS_CLEAR, 32'h0000_007F);
      repeat (3) @(posedge hclk);
      #1 chk(32'(wake_out), 32'(s[0]));
      u_phy.magic();
      evt(7'h04);
      repeat (4) @(posedge hclk);
      #1 chk(32'(wake_out), 32'(!s[0]));
    end
    test_done();
  end
endmodule : ewol_unit_bench
